/* rrh_params.svh */
`ifndef RRH_PARAMS_SVH
`define RRH_PARAMS_SVH
// signal byte bit positions
`define RRH_REQ_BIT 0
`define RRH_MODE_BIT 7
`define RRH_PREVIEW_BIT 0
`define RRH_ACTIVE_BIT 2
`define RRH_DONE_BIT 0
`define RRH_SKIP_BIT 2
`define RRH_ERR_BIT 3
`define RRH_RESTART_BIT 4
// z retract amount limit and reset value
`define RRH_ZAMT_MAX 32'd99999999
`define RRH_ZAMT_RST 32'h0000_0000
// controller apb register offsets
`define RRH_OFS_CTRL 12'h000
`define RRH_OFS_ZAMT 12'h004
`define RRH_OFS_STAT 12'h008
`define RRH_OFS_CMD 12'h00C
// controller ctrl register fields
`define RRH_CTRL_REQ 0
`define RRH_CTRL_MODE 1
`define RRH_CTRL_AOS 2
`define RRH_CTRL_WAITPV 3
`define RRH_CTRL_RST 32'h0000_0000
// controller cmd register fields (write one pulses)
`define RRH_CMD_START 0
`define RRH_CMD_RESET 1
`endif

/* rrh_pkg.sv */
package rrh_pkg;
    typedef enum logic [2:0] {
        RRH_IDLE = 3'b000,
        RRH_ZRET = 3'b001,
        RRH_BACK = 3'b010,
        RRH_SKZ = 3'b011,
        RRH_SKPOS = 3'b100,
        RRH_HOLD = 3'b101
    } rrh_state_e;
    typedef logic [7:0] rrh_byte_t;
endpackage

/* rrh_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rrh_if;
    import rrh_pkg::*;
    rrh_byte_t retrace_request_byte;
    rrh_byte_t retry_mode_select_byte;
    logic auto_operation_stop;
    logic cycle_start;
    logic reset_button;
    logic [31:0] z_retract_amount;
    rrh_byte_t preview_status_byte;
    rrh_byte_t retrace_active_byte;
    rrh_byte_t retry_result_byte;
    logic distribution_end_flag;
    logic aux_strobe;
    rrh_byte_t aux_code;
    modport device (
        input retrace_request_byte, retry_mode_select_byte, auto_operation_stop,
        input cycle_start, reset_button, z_retract_amount,
        output preview_status_byte, retrace_active_byte, retry_result_byte,
        output distribution_end_flag, aux_strobe, aux_code
    );
    modport controller (
        output retrace_request_byte, retry_mode_select_byte, auto_operation_stop,
        output cycle_start, reset_button, z_retract_amount,
        input preview_status_byte, retrace_active_byte, retry_result_byte,
        input distribution_end_flag, aux_strobe, aux_code
    );
endinterface // rrh_if
`default_nettype wire

/* rrh_device.sv */
// Function
// - mode 0 request ignored, 1 retry processing
// - controller changes mode only before request
// - request rise retracts z, then traces back
// - request fall with start resumes forward
// - active flag set on rise, cleared on fall
// - aux codes run same during retrace
// - aux strobe position differs, controller qualifies (controller here leaves aux strobe and code unused)
// - done flag on distance or skip end
// - skip and done flags set, clear together
// - cannot-continue on piercing or gas failure (piercing here only once retry count reaches limit)
// - cannot-continue cleared by start or reset (start here clears it only together with the request fall)
// - controller ends machining, never retries again
// - failure turns preview mode off
// - block-end stop, preview back, restart flag
// - controller checks restart flag before start
// - preview flag follows preview selection
// - z retract by amount, zero means none
// - retry limit exceeded performs skip sequence
// - zero retrace distance performs skip
`include "rrh_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rrh_device
    import rrh_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    rrh_if.device link,
    input wire logic machining_failure,
    input wire logic in_piercing,
    input wire logic in_assist_gas,
    input wire logic retry_ok,
    input wire logic [CNT_W-1:0] retry_limit,
    input wire logic [15:0] retrace_distance,
    input wire logic distance_reached,
    input wire logic no_block_left,
    input wire logic block_end_reached,
    input wire logic z_done,
    input wire logic preview_select,
    input wire logic motion_den,
    input wire logic aux_strobe_in,
    input wire logic [7:0] aux_code_in,
    output logic z_retract_go,
    output logic [31:0] z_retract_dist,
    output logic trace_backward,
    output logic forward_resume,
    output logic beam_off,
    output logic gas_off,
    output logic tracing_off,
    output logic single_block_stop
);
    rrh_state_e state_q, state_d;
    logic req_q;
    logic req_rise, req_fall_start, start_ok, skip_now;
    logic active_q, done_q, skip_q, err_q, restart_q, pv_off_q;
    logic [CNT_W-1:0] retries_q;
    logic [31:0] zamt;
    logic skip_out_q, zgo_q, fwd_q, sbs_q;
    logic [31:0] zdist_q;
    logic aux_stb_q, den_q;
    logic [7:0] aux_code_q;

    function automatic logic [31:0] clamp_zamt(input logic [31:0] v);
        clamp_zamt = (v > `RRH_ZAMT_MAX) ? `RRH_ZAMT_MAX : v;
    endfunction

    wire logic req = link.retrace_request_byte[`RRH_REQ_BIT];
    wire logic mode = link.retry_mode_select_byte[`RRH_MODE_BIT];
    wire logic aos = link.auto_operation_stop;

    assign zamt = clamp_zamt(link.z_retract_amount);
    assign req_rise = req && !req_q && mode && aos;
    assign req_fall_start = !req && req_q && link.cycle_start && !aos;
    // retry limit overrun or zero distance skips instead of retracing
    assign skip_now = mode && ((retries_q > retry_limit) ||
        (retrace_distance == 16'h0000));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req;
        end
    end

    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            RRH_IDLE: begin
                if (req_rise) begin
                    state_d = skip_now ? RRH_SKZ : RRH_ZRET;
                end
            end
            RRH_ZRET: begin
                if (zamt == 32'h0000_0000 || z_done) begin
                    state_d = RRH_BACK;
                end
            end
            RRH_BACK: begin
                if (distance_reached || no_block_left) begin
                    state_d = RRH_HOLD;
                end
            end
            RRH_SKZ: begin
                if (zamt == 32'h0000_0000 || z_done) begin
                    state_d = RRH_SKPOS;
                end
            end
            RRH_SKPOS: begin
                if (block_end_reached) begin
                    state_d = RRH_HOLD;
                end
            end
            RRH_HOLD: begin
                if (req_fall_start) begin
                    state_d = RRH_IDLE;
                end
            end
            default: begin
                state_d = RRH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RRH_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // z retract command, one pulse with the amount held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zgo_q <= 1'b0;
            zdist_q <= `RRH_ZAMT_RST;
        end else begin
            zgo_q <= (state_d == RRH_ZRET || state_d == RRH_SKZ) && state_q == RRH_IDLE &&
                zamt != 32'h0000_0000;
            if (state_q == RRH_IDLE) begin
                zdist_q <= zamt;
            end
        end
    end

    // retrace in progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
        end else if (state_q == RRH_IDLE && req_rise && !skip_now) begin
            active_q <= 1'b1;
        end else if (req_fall_start || (state_q == RRH_BACK && no_block_left)) begin
            active_q <= 1'b0;
        end
    end

    // retrace done and skip done, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            skip_q <= 1'b0;
        end else if (state_q == RRH_BACK && distance_reached) begin
            done_q <= 1'b1;
        end else if (state_q == RRH_SKPOS && block_end_reached) begin
            done_q <= 1'b1;
            skip_q <= 1'b1;
        end else if (req_fall_start) begin
            done_q <= 1'b0;
            skip_q <= 1'b0;
        end
    end

    // skip outputs: beam, gas and tracing off from skip start to resume
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_out_q <= 1'b0;
        end else if (state_q == RRH_IDLE && state_d == RRH_SKZ) begin
            skip_out_q <= 1'b1;
        end else if (req_fall_start) begin
            skip_out_q <= 1'b0;
        end
    end

    // retry count, cleared when a retry completes normally
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retries_q <= '0;
        end else if (mode && machining_failure && !(&retries_q)) begin
            retries_q <= retries_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (retry_ok || !mode) begin
            retries_q <= '0;
        end
    end

    // cannot continue, set wins over either clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if (mode && machining_failure &&
            ((in_piercing && retries_q >= retry_limit) || in_assist_gas)) begin
            err_q <= 1'b1;
        end else if (req_fall_start || link.reset_button) begin
            err_q <= 1'b0;
        end
    end

    // advanced preview suppression and restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pv_off_q <= 1'b0;
            restart_q <= 1'b0;
            sbs_q <= 1'b0;
        end else begin
            sbs_q <= (state_q == RRH_SKPOS && block_end_reached) ||
                (pv_off_q && state_q == RRH_IDLE && block_end_reached);
            if (mode && machining_failure && preview_select) begin
                pv_off_q <= 1'b1;
            end else if (pv_off_q && state_q == RRH_IDLE && block_end_reached) begin
                pv_off_q <= 1'b0;
            end
            if (pv_off_q && state_q == RRH_IDLE && block_end_reached) begin
                restart_q <= 1'b1;
            end else if (link.cycle_start) begin
                restart_q <= 1'b0;
            end
        end
    end

    // resume pulse and aux pass-through, same in both directions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_q <= 1'b0;
            aux_stb_q <= 1'b0;
            aux_code_q <= 8'h00;
            den_q <= 1'b0;
        end else begin
            fwd_q <= req_fall_start && state_q == RRH_HOLD;
            aux_stb_q <= aux_strobe_in;
            aux_code_q <= aux_code_in;
            den_q <= motion_den;
        end
    end

    assign link.preview_status_byte = {7'h00, preview_select && !pv_off_q};
    assign link.retrace_active_byte = {5'h00, active_q, 2'h0};
    assign link.retry_result_byte = {3'h0, restart_q, err_q, skip_q, 1'b0, done_q};
    assign link.distribution_end_flag = den_q;
    assign link.aux_strobe = aux_stb_q;
    assign link.aux_code = aux_code_q;
    assign z_retract_go = zgo_q;
    assign z_retract_dist = zdist_q;
    assign trace_backward = active_q && state_q == RRH_BACK;
    assign forward_resume = fwd_q;
    assign beam_off = skip_out_q;
    assign gas_off = skip_out_q;
    assign tracing_off = skip_out_q;
    assign single_block_stop = sbs_q;
endmodule // rrh_device
`default_nettype wire

/* rrh_controller.sv */
`include "rrh_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rrh_controller
    import rrh_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    rrh_if.controller link,
    output logic end_machining
);
    logic [31:0] ctrl_q, zamt_q, prdata_q;
    logic req_q, mode_q, start_q, start_pend_q, rst_q, lock_q;
    logic wr, rd, mapped;
    logic start_cmd, want_req, fall_ok, start_fire;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign mapped = paddr == `RRH_OFS_CTRL || paddr == `RRH_OFS_ZAMT ||
        paddr == `RRH_OFS_STAT || paddr == `RRH_OFS_CMD;
    assign start_cmd = wr && paddr == `RRH_OFS_CMD && pwdata[`RRH_CMD_START];
    assign want_req = ctrl_q[`RRH_CTRL_REQ];
    // lowering the request waits for the stop input to drop
    assign fall_ok = req_q && !want_req && !ctrl_q[`RRH_CTRL_AOS];
    // a pending start may wait for the restart flag; it fires once only
    assign start_fire = start_pend_q && (!ctrl_q[`RRH_CTRL_WAITPV] ||
        link.retry_result_byte[`RRH_RESTART_BIT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `RRH_CTRL_RST;
            zamt_q <= `RRH_ZAMT_RST;
        end else if (wr && paddr == `RRH_OFS_CTRL) begin
            ctrl_q <= pwdata;
        end else if (wr && paddr == `RRH_OFS_ZAMT) begin
            zamt_q <= pwdata;
        end
    end

    // request output; no new rise once machining is locked out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 1'b0;
        end else if (!req_q && want_req && !lock_q) begin
            req_q <= 1'b1;
        end else if (fall_ok) begin
            req_q <= 1'b0;
        end
    end

    // mode changes only while request is low and no retrace runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 1'b0;
        end else if (!req_q && !want_req &&
            !link.retrace_active_byte[`RRH_ACTIVE_BIT]) begin
            mode_q <= ctrl_q[`RRH_CTRL_MODE];
        end
    end

    // cycle start: with the fall, or on command; optionally gated by restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= 1'b0;
            start_pend_q <= 1'b0;
        end else begin
            start_q <= fall_ok || start_fire;
            if (start_cmd) begin
                start_pend_q <= 1'b1;
            end else if (start_fire || fall_ok) begin
                start_pend_q <= 1'b0;
            end
        end
    end

    // cannot-continue latches end of machining until power reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_q <= wr && paddr == `RRH_OFS_CMD && pwdata[`RRH_CMD_RESET];
            if (link.retry_result_byte[`RRH_ERR_BIT]) begin
                lock_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `RRH_OFS_CTRL: prdata_q <= ctrl_q;
                `RRH_OFS_ZAMT: prdata_q <= zamt_q;
                `RRH_OFS_STAT: prdata_q <= {12'h000, lock_q, mode_q, req_q,
                    link.distribution_end_flag, link.preview_status_byte,
                    link.retrace_active_byte[`RRH_ACTIVE_BIT],
                    link.retry_result_byte[6:0]};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = rd ? prdata_q : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign link.retrace_request_byte = {7'h00, req_q};
    assign link.retry_mode_select_byte = {mode_q, 7'h00};
    assign link.auto_operation_stop = ctrl_q[`RRH_CTRL_AOS];
    assign link.cycle_start = start_q;
    assign link.reset_button = rst_q;
    assign link.z_retract_amount = zamt_q;
    assign end_machining = lock_q;
endmodule // rrh_controller
`default_nettype wire

/* rrh_handshake_asserts.sv */
`include "rrh_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rrh_handshake_asserts
    import rrh_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire rrh_byte_t retrace_request_byte,
    input wire rrh_byte_t retry_mode_select_byte,
    input wire logic auto_operation_stop,
    input wire logic cycle_start,
    input wire logic reset_button,
    input wire rrh_byte_t retrace_active_byte,
    input wire rrh_byte_t retry_result_byte
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic req = retrace_request_byte[`RRH_REQ_BIT];
    wire logic mode = retry_mode_select_byte[`RRH_MODE_BIT];
    wire logic act = retrace_active_byte[`RRH_ACTIVE_BIT];
    wire logic done = retry_result_byte[`RRH_DONE_BIT];
    wire logic skip = retry_result_byte[`RRH_SKIP_BIT];
    wire logic err = retry_result_byte[`RRH_ERR_BIT];
    wire logic clr_ev = !req && cycle_start;
    a_active_on_rise: assert property ($rose(act) |-> $past(req) && !$past(req, 2) &&
        $past(mode) && $past(auto_operation_stop))
        else $error("active flag rose without accepted request");
    a_rise_not_taken: assert property ($rose(req) && !(mode && auto_operation_stop) && !act
        |=> !act)
        else $error("request taken without mode and stop");
    a_fall_with_start: assert property ($fell(req) |-> cycle_start && !auto_operation_stop)
        else $error("request fell without cycle start");
    a_fall_clears_all: assert property ($fell(req) && cycle_start
        |=> !act && !done && !skip && !err)
        else $error("flags not cleared by resume");
    a_skip_sets_done: assert property ($rose(skip) |-> $rose(done))
        else $error("skip flag rose apart from done flag");
    a_skip_clr_done: assert property ($fell(skip) |-> $fell(done))
        else $error("skip flag fell apart from done flag");
    a_done_holds: assert property (done && !clr_ev && !reset_button |=> done)
        else $error("done flag dropped without resume");
    a_err_holds: assert property (err && !clr_ev && !reset_button |=> err)
        else $error("cannot-continue flag dropped on its own");
    a_err_reset_btn: assert property (reset_button |=> !err)
        else $error("reset button left cannot-continue set");
    a_mode_steady: assert property (act |-> $stable(mode))
        else $error("mode changed while retracing");
    c_retrace: cover property ($rose(act));
    c_skip: cover property ($rose(skip));
    c_err: cover property ($rose(err));
endmodule // rrh_handshake_asserts
`default_nettype wire

/* retrace_retry_handshake_test.sv */
`include "rrh_params.svh"
`timescale 1ns/1ps
`default_nettype none
module retrace_retry_handshake_test;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, end_mach;
    logic fail_p = 1'h0, pierce = 1'h0, zd_p = 1'h0, dist_p = 1'h0, bend_p = 1'h0;
    logic pv_sel = 1'h0, den_in = 1'h0, aux_stb = 1'h0, gas_p = 1'h0;
    logic [15:0] rlimit = 16'h0005;
    logic [15:0] rdist = 16'h0010;
    logic [7:0] aux_cd = 8'h00;
    logic z_go, trace_bk, fwd, beam_off, gas_off, trc_off, sbs;
    logic [31:0] z_dist;
    int err_total = 0;
    int checks_done = 0;
    always #4 pclk = ~pclk;
    rrh_if link_if ();
    rrh_device i_rrh_device (.pclk(pclk), .presetn(presetn), .link(link_if),
        .machining_failure(fail_p), .in_piercing(pierce), .in_assist_gas(gas_p),
        .retry_ok(1'h0), .retry_limit(rlimit), .retrace_distance(rdist),
        .distance_reached(dist_p), .no_block_left(1'h0), .block_end_reached(bend_p),
        .z_done(zd_p), .preview_select(pv_sel), .motion_den(den_in), .aux_strobe_in(aux_stb),
        .aux_code_in(aux_cd), .z_retract_go(z_go), .z_retract_dist(z_dist),
        .trace_backward(trace_bk), .forward_resume(fwd), .beam_off(beam_off),
        .gas_off(gas_off), .tracing_off(trc_off), .single_block_stop(sbs));
    rrh_controller i_rrh_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link_if), .end_machining(end_mach));
    rrh_handshake_asserts i_rrh_handshake_asserts (.pclk(pclk), .presetn(presetn),
        .retrace_request_byte(link_if.retrace_request_byte),
        .retry_mode_select_byte(link_if.retry_mode_select_byte),
        .auto_operation_stop(link_if.auto_operation_stop), .cycle_start(link_if.cycle_start),
        .reset_button(link_if.reset_button), .retrace_active_byte(link_if.retrace_active_byte),
        .retry_result_byte(link_if.retry_result_byte));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic se);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            $display("unexpected pready expected 1 seen %b", pready);
            err_total++;
            close_out();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic se;
        apb(1'h1, a, v, d, se);
    endtask
    task automatic stat(input string nm, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic se;
        apb(1'h0, `RRH_OFS_STAT, 32'h0000_0000, d, se);
        chk(nm, e, d & m);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: pick = z_go;
            1: pick = beam_off;
            2: pick = sbs;
            default: pick = fwd;
        endcase
    endfunction
    task automatic wait_hi(input int s);
        int n;
        n = 0;
        #1;
        while (pick(s) !== 1'h1 && n < 50) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (pick(s) !== 1'h1) begin
            $display("unexpected wait on output %0d expected 1 seen 0", s);
            err_total++;
            close_out();
        end
    endtask
    task automatic pulse(input int s);
        @(posedge pclk);
        case (s)
            0: zd_p <= 1'h1;
            1: dist_p <= 1'h1;
            2: bend_p <= 1'h1;
            default: fail_p <= 1'h1;
        endcase
        @(posedge pclk);
        {zd_p, dist_p, bend_p, fail_p} <= 4'h0;
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic se;
        apb(1'h0, `RRH_OFS_ZAMT, 32'h0000_0000, d, se);
        chk("zamt reset", 32'h0000_0000, d);
        wr(`RRH_OFS_ZAMT, 32'h0000_1234);
        apb(1'h0, `RRH_OFS_ZAMT, 32'h0000_0000, d, se);
        chk("zamt readback", 32'h0000_1234, d);
        apb(1'h0, 12'h010, 32'h0000_0000, d, se);
        chk_bit("unmapped slverr", 1'h1, se);
        chk("unmapped data", 32'h0000_0000, d);
    endtask
    task automatic t_ignored();
        wr(`RRH_OFS_CTRL, 32'h0000_0005);
        stat("active mode 0", 32'h0000_0080, 32'h0000_0000);
        wr(`RRH_OFS_CTRL, 32'h0000_0000);
    endtask
    task automatic t_retrace();
        wr(`RRH_OFS_CTRL, 32'h0000_0006);
        wr(`RRH_OFS_CTRL, 32'h0000_0007);
        wait_hi(0);
        chk("z distance", 32'h0000_1234, z_dist);
        stat("active set", 32'h0000_0080, 32'h0000_0080);
        pulse(0);
        @(posedge pclk);
        den_in <= 1'h1;
        aux_stb <= 1'h1;
        aux_cd <= 8'hA5;
        #1;
        chk_bit("trace backward", 1'h1, trace_bk);
        @(posedge pclk);
        {den_in, aux_stb} <= 2'h0;
        #1;
        chk("aux code", 32'h0000_00A5, {24'h0, link_if.aux_code});
        chk_bit("aux strobe", 1'h1, link_if.aux_strobe);
        chk_bit("den flag", 1'h1, link_if.distribution_end_flag);
        pulse(1);
        stat("done set", 32'h0000_0081, 32'h0000_0081);
        wr(`RRH_OFS_CTRL, 32'h0000_0002);
        wait_hi(3);
        stat("flags after resume", 32'h0000_009D, 32'h0000_0000);
    endtask
    task automatic t_skip();
        rdist <= 16'h0000;
        wr(`RRH_OFS_ZAMT, 32'hFFFF_FFFF);
        wr(`RRH_OFS_CTRL, 32'h0000_0006);
        wr(`RRH_OFS_CTRL, 32'h0000_0007);
        wait_hi(1);
        chk_bit("gas off", 1'h1, gas_off);
        chk_bit("tracing off", 1'h1, trc_off);
        chk_bit("z go", 1'h1, z_go);
        chk("z clamp", 32'h05F5_E0FF, z_dist);
        pulse(0);
        pulse(2);
        wait_hi(2);
        stat("skip and done", 32'h0000_001D, 32'h0000_0005);
        wr(`RRH_OFS_CTRL, 32'h0000_0002);
        wait_hi(3);
        stat("skip cleared", 32'h0000_001D, 32'h0000_0000);
        chk_bit("beam back on", 1'h0, beam_off);
        rdist <= 16'h0010;
    endtask
    task automatic t_preview();
        pv_sel <= 1'h1;
        stat("preview on", 32'h0000_0100, 32'h0000_0100);
        pulse(3);
        stat("preview dropped", 32'h0000_0100, 32'h0000_0000);
        wr(`RRH_OFS_CTRL, 32'h0000_000A);
        wr(`RRH_OFS_CMD, 32'h0000_0001);
        pulse(2);
        wait_hi(2);
        chk_bit("restart set", 1'h1, link_if.retry_result_byte[`RRH_RESTART_BIT]);
        @(posedge pclk);
        stat("restart consumed", 32'h0000_0110, 32'h0000_0100);
        wr(`RRH_OFS_CMD, 32'h0000_0001);
        pv_sel <= 1'h0;
        stat("restart cleared", 32'h0000_0110, 32'h0000_0000);
    endtask
    task automatic t_cannot();
        rlimit <= 16'h0000;
        pierce <= 1'h1;
        pulse(3);
        pierce <= 1'h0;
        stat("cannot continue", 32'h0000_0008, 32'h0000_0008);
        chk_bit("end machining", 1'h1, end_mach);
        wr(`RRH_OFS_CMD, 32'h0000_0002);
        @(posedge pclk);
        stat("reset button", 32'h0000_0008, 32'h0000_0000);
        gas_p <= 1'h1;
        pulse(3);
        gas_p <= 1'h0;
        stat("gas failure", 32'h0000_0008, 32'h0000_0008);
        wr(`RRH_OFS_CTRL, 32'h0000_0006);
        wr(`RRH_OFS_CTRL, 32'h0000_0007);
        stat("no retry after lock", 32'h0002_0080, 32'h0000_0000);
        chk_bit("lock held", 1'h1, end_mach);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_ignored();
        t_retrace();
        t_skip();
        t_preview();
        t_cannot();
        close_out();
    end
endmodule // retrace_retry_handshake_test
`default_nettype wire
